// *** include/umsel_pkg.sv ***
// Shared constants and carrier types for the user-control profile select block.
// Assumes one 20 MHz system clock; registers reached over Avalon-MM.
package umsel_pkg;
	// Clock period in ns
	localparam int CLK_NS = 50;
	// Generic switch debounce time in us and its cycle count
	localparam int SW_DEB_US = 5000;
	localparam int SW_DEB_CYC = (SW_DEB_US * 1000) / CLK_NS;
	// Register byte offsets
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_VALID = 6'h04;
	localparam logic [5:0] OFS_COILDEB = 6'h08;
	localparam logic [5:0] OFS_FADE = 6'h0C;
	localparam logic [5:0] OFS_STATUS = 6'h10;
	localparam logic [5:0] OFS_TRIMMAP = 6'h14;
	// Reset values
	localparam logic [12:0] CTRL_RST = 13'h0400;
	localparam logic [3:0] VALID_RST = 4'h1;
	localparam logic [15:0] COILDEB_RST = 16'hFFFF;
	localparam logic [15:0] FADE_RST = 16'h0100;
	// Profiles
	localparam logic [1:0] PROF_A = 2'h0;
	localparam logic [1:0] PROF_B = 2'h1;
	localparam logic [1:0] PROF_D = 2'h3;
	// Trimmer map geometry
	localparam int NPAR = 19;
	localparam int NTRIM = 4;
	localparam logic [2:0] CH_VOL = 3'h4;
	localparam logic [2:0] MAP_NONE = 3'h7;
	// Gain limits
	localparam logic [5:0] GAIN_MAX = 6'h3F;
	localparam logic [5:0] GAIN_RST = 6'h20;
	// Switch pin indices
	localparam int SW_A = 0;
	localparam int SW_B = 1;
	localparam int SW_UP = 2;
	localparam int SW_DN = 3;
	// Control register fields
	typedef struct packed {
		logic vol_pu;       // Volume pins pulled up, closure low
		logic trim_en;      // Trimmer mode
		logic ind_en;       // Indicator playback on change
		logic log_taper;    // Analog volume log taper
		logic rocker_ms;    // Rocker drives profile select
		logic vol_ana;      // Analog volume enable
		logic vol_dig;      // Digital volume enable
		logic b_dis;        // Second select input disabled
		logic coil_en;      // Auto coil, fourth profile reserved
		logic b_pu;         // Second input pull-up
		logic a_pu;         // First input pull-up
		logic b_static;     // Second input static switch
		logic a_static;     // First input static switch
	} umsel_ctrl_t;
	// Converter sample carrier
	typedef struct packed {
		logic vld;
		logic [2:0] ch;
		logic [7:0] pos;
	} umsel_smp_t;
endpackage

// *** rtl/umsel_deb.sv ***
// Synchroniser and level debouncer for one switch pin.
// Assumes an asynchronous raw pin; output level is stable for CNT cycles.
`timescale 1ns/10ps
`default_nettype none
module umsel_deb import umsel_pkg::*; #(
	parameter int CNT = SW_DEB_CYC
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic raw,
	output logic lvl
);
	// All state of the debouncer
	typedef struct packed {
		logic s1;          // First sync stage
		logic s2;          // Second sync stage
		logic [$clog2(CNT+1)-1:0] cnt; // Agreement counter
		logic lvl;         // Filtered level
	} umsel_deb_t;
	umsel_deb_t st_r, st_nxt;
	// Next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = raw;
		st_nxt.s2 = st_r.s1;
		if (st_r.s2 == st_r.lvl) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt == ($clog2(CNT+1))'(CNT - 1)) begin
			st_nxt.cnt = '0;
			st_nxt.lvl = st_r.s2;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end
	// State register
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
	assign lvl = st_r.lvl;
endmodule // umsel_deb
`default_nettype wire

// *** rtl/umsel_top.sv ***
// Profile select, auto coil, volume and trimmer mapping control.
// Assumes switch pins are asynchronous and converter samples are on MCLK.
// What this block does
// - Momentary first select starts in profile A
// - Press loads next valid profile, ascending order
// - Past last valid profile wraps to A
// - First input steps among the four profiles; second input only drives auto coil
// - First input set momentary or static; second input static bit has no effect
// - Each input selects pull-up or pull-down
// - Auto coil: closed second input enters D
// - After debounced open, return to prior profile
// - Debounce starts on closed-to-open change
// - Leave D only after full open period
// - Each change fades audio, optional indicator
// - Indicator chosen by destination profile
// - Coil mode may disable second input
// - Up pin raises gain, down lowers
// - Only one volume control source enabled
// - Rocker may also drive profile select
// - Analog volume log or linear taper
// - Converter samples four trimmers plus volume
// - Trimmer change updates parameters at once
// - Nineteen parameters, sixteen values, shared trimmers
// - Rocker action happens on release
//
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module umsel_top import umsel_pkg::*; #(
	parameter int SW_DEB = SW_DEB_CYC
) (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic PROFILE_SELECT_IN_A,
	input wire logic PROFILE_SELECT_IN_B,
	input wire logic VOLUME_UP_PIN,
	input wire logic VOLUME_DOWN_PIN,
	output logic [1:0] PULL_UP_EN,
	output logic [1:0] PULL_DOWN_EN,
	input wire umsel_smp_t TRIM_SAMPLE,
	output logic [1:0] PROFILE,
	output logic FADE_OUT,
	output logic INDICATOR_REQ,
	output logic [1:0] INDICATOR_ID,
	output logic [5:0] VOL_GAIN,
	output logic [NPAR*4-1:0] PARAM_VAL
);
	// All state of the block
	typedef struct packed {
		umsel_ctrl_t ctrl;             // Control bits
		logic [3:0] valid;             // Valid profile mask
		logic [15:0] coil_per;         // Coil open debounce cycles
		logic [15:0] fade_len;         // Fade length cycles
		logic [NPAR-1:0][2:0] map;     // Trimmer source per parameter
		logic [1:0] prof;              // Active profile
		logic [1:0] saved;             // Profile before coil entry
		logic in_coil;                 // Coil profile active
		logic [15:0] open_cnt;         // Open samples counted
		logic [15:0] fade_cnt;         // Fade cycles left
		logic fade;                    // Fade output
		logic ind_req;                 // Indicator request pulse
		logic [1:0] ind_id;            // Indicator choice
		logic [5:0] gain;              // Volume gain
		logic [1:0] pull_dn; // Pull-down enables, own flops
		logic [NPAR-1:0][3:0] par;     // Parameter values
		logic [3:0] prev;              // Closure level last cycle
		logic wait_r;                  // Bus waitrequest
		logic [31:0] rdata;            // Bus read data
	} umsel_st_t;
	umsel_st_t st_r, st_nxt;
	// Control word after reset, as fields
	localparam umsel_ctrl_t CTRL_INIT = umsel_ctrl_t'(CTRL_RST);
	// Debounced pin levels
	logic [3:0] raw, lvl, closed, rel;
	logic [3:0] pu;
	logic [3:0] vmask;
	logic [1:0] up_tgt, dn_tgt;
	logic b_closed, busy, a_take, coil_enter, coil_leave, req;
	logic [15:0] map_word;
	assign raw = {VOLUME_DOWN_PIN, VOLUME_UP_PIN, PROFILE_SELECT_IN_B, PROFILE_SELECT_IN_A};
	// One debouncer per switch pin
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_sw
			umsel_deb #(.CNT(SW_DEB)) u_deb (
				.MCLK(MCLK),
				.RST_N(RST_N),
				.raw(raw[gi]),
				.lvl(lvl[gi])
			);
		end
	endgenerate
	// Closure polarity follows the pull choice
	assign pu = {st_r.ctrl.vol_pu, st_r.ctrl.vol_pu, st_r.ctrl.b_pu, st_r.ctrl.a_pu};
	assign closed = lvl ^ pu;
	// Release edge of a debounced closure
	assign rel = st_r.prev & ~closed;
	// Profile A always counts as valid; D reserved in coil mode
	always_comb begin
		vmask = st_r.valid | 4'h1;
		if (st_r.ctrl.coil_en) begin
			vmask[PROF_D] = 1'b0;
		end
	end
	// Next valid profile upward, else A
	always_comb begin
		up_tgt = PROF_A;
		for (int i = 3; i >= 1; i--) begin
			if (i > st_r.prof && vmask[i]) begin
				up_tgt = 2'(i);
			end
		end
	end
	// Next valid profile downward, else highest valid
	always_comb begin
		dn_tgt = PROF_A;
		for (int i = 0; i <= 3; i++) begin
			if (vmask[i]) begin
				dn_tgt = 2'(i);
			end
		end
		for (int i = 0; i <= 2; i++) begin
			if (i < st_r.prof && vmask[i]) begin
				dn_tgt = 2'(i);
			end
		end
	end
	// Event qualifiers
	assign busy = st_r.fade_cnt != '0;
	assign b_closed = closed[SW_B] && st_r.ctrl.coil_en && !st_r.ctrl.b_dis;
	assign coil_enter = !st_r.in_coil && b_closed && !busy;
	assign coil_leave = st_r.in_coil && !b_closed && !busy && st_r.open_cnt >= st_r.coil_per;
	assign a_take = !st_r.ctrl.a_static && !st_r.in_coil && !busy && rel[SW_A];
	assign req = AVS_READ || AVS_WRITE;
	assign map_word = {8'h00, st_r.map[AVS_WRITEDATA[4:0] % NPAR], AVS_WRITEDATA[4:0]};
	// Next state of the whole block
	always_comb begin
		logic chg;
		logic [1:0] tgt;
		logic [31:0] wd;
		logic [31:0] cur;
		logic [8:0] sq;
		chg = 1'b0;
		tgt = st_r.prof;
		wd = '0;
		cur = '0;
		sq = '0;
		st_nxt = st_r;
		st_nxt.prev = closed;
		st_nxt.ind_req = 1'b0;
		// Coil open counter, restarted by any closed sample
		if (!st_r.in_coil || b_closed) begin
			st_nxt.open_cnt = '0;
		end else if (st_r.open_cnt != 16'hFFFF) begin
			st_nxt.open_cnt = st_r.open_cnt + 16'h0001;
		end
		// Profile selection by priority
		if (coil_enter) begin
			st_nxt.saved = st_r.prof;
			st_nxt.in_coil = 1'b1;
			tgt = PROF_D;
			chg = 1'b1;
		end else if (coil_leave) begin
			st_nxt.in_coil = 1'b0;
			tgt = st_r.saved;
			chg = 1'b1;
		end else if (a_take) begin
			tgt = up_tgt;
			chg = 1'b1;
		end else if (st_r.ctrl.a_static && !st_r.in_coil && !busy) begin
			// Static first input: closed picks B when valid
			tgt = (closed[SW_A] && vmask[PROF_B]) ? PROF_B : PROF_A;
			chg = 1'b1;
		end else if (st_r.ctrl.rocker_ms && st_r.ctrl.vol_dig && !st_r.in_coil && !busy) begin
			if (rel[SW_UP]) begin
				tgt = up_tgt;
				chg = 1'b1;
			end else if (rel[SW_DN]) begin
				tgt = dn_tgt;
				chg = 1'b1;
			end
		end
		// A real change starts the fade and indicator
		if (chg && tgt != st_r.prof) begin
			st_nxt.prof = tgt;
			st_nxt.fade_cnt = (st_r.fade_len == '0) ? 16'h0001 : st_r.fade_len;
			st_nxt.ind_req = st_r.ctrl.ind_en;
			st_nxt.ind_id = tgt;
		end else if (busy) begin
			st_nxt.fade_cnt = st_r.fade_cnt - 16'h0001;
		end
		st_nxt.fade = st_nxt.fade_cnt != '0;
		// Digital volume on button release
		if (st_r.ctrl.vol_dig && !st_r.ctrl.rocker_ms) begin
			if (rel[SW_UP] && st_r.gain != GAIN_MAX) begin
				st_nxt.gain = st_r.gain + 6'h01;
			end else if (rel[SW_DN] && st_r.gain != '0) begin
				st_nxt.gain = st_r.gain - 6'h01;
			end
		end
		// Converter samples: volume pot and trimmers
		if (TRIM_SAMPLE.vld) begin
			if (TRIM_SAMPLE.ch == CH_VOL && st_r.ctrl.vol_ana) begin
				sq = 9'((16'(TRIM_SAMPLE.pos) * 16'(TRIM_SAMPLE.pos)) >> 7);
				st_nxt.gain = st_r.ctrl.log_taper ? sq[8:3] : TRIM_SAMPLE.pos[7:2];
			end else if (st_r.ctrl.trim_en && TRIM_SAMPLE.ch < 3'(NTRIM)) begin
				for (int p = 0; p < NPAR; p++) begin
					if (st_r.map[p] == TRIM_SAMPLE.ch) begin
						st_nxt.par[p] = TRIM_SAMPLE.pos[7:4];
					end
				end
			end
		end
		// Avalon slave: answer one cycle after request, act on release edge
		if (req && st_r.wait_r) begin
			st_nxt.wait_r = 1'b0;
			unique case (AVS_ADDRESS)
				OFS_CTRL: st_nxt.rdata = 32'(st_r.ctrl);
				OFS_VALID: st_nxt.rdata = 32'(st_r.valid);
				OFS_COILDEB: st_nxt.rdata = 32'(st_r.coil_per);
				OFS_FADE: st_nxt.rdata = 32'(st_r.fade_len);
				OFS_STATUS: st_nxt.rdata = {16'h0000, st_r.gain, busy, st_r.fade, st_r.in_coil,
					st_r.ind_id, st_r.saved, st_r.prof, 1'b0};
				OFS_TRIMMAP: st_nxt.rdata = 32'(map_word);
				default: st_nxt.rdata = '0;
			endcase
		end else if (req) begin
			st_nxt.wait_r = 1'b1;
			if (AVS_WRITE) begin
				unique case (AVS_ADDRESS)
					OFS_CTRL: cur = 32'(st_r.ctrl);
					OFS_VALID: cur = 32'(st_r.valid);
					OFS_COILDEB: cur = 32'(st_r.coil_per);
					OFS_FADE: cur = 32'(st_r.fade_len);
					default: cur = '0;
				endcase
				for (int b = 0; b < 4; b++) begin
					wd[b*8 +: 8] = AVS_BYTEENABLE[b] ? AVS_WRITEDATA[b*8 +: 8] : cur[b*8 +: 8];
				end
				unique case (AVS_ADDRESS)
					OFS_CTRL: begin
						st_nxt.ctrl = umsel_ctrl_t'(wd[12:0]);
						st_nxt.ctrl.vol_ana = st_nxt.ctrl.vol_ana && !st_nxt.ctrl.vol_dig;
					end
					OFS_VALID: st_nxt.valid = wd[3:0];
					OFS_COILDEB: st_nxt.coil_per = wd[15:0];
					OFS_FADE: st_nxt.fade_len = wd[15:0];
					OFS_TRIMMAP: begin
						if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[4:0] < 5'(NPAR)) begin
							st_nxt.map[AVS_WRITEDATA[4:0]] = AVS_WRITEDATA[7:5];
						end
					end
					default: ;
				endcase
			end
		end
		// Pull-downs are the complement of the pull-ups
		st_nxt.pull_dn = ~{st_nxt.ctrl.b_pu, st_nxt.ctrl.a_pu};
	end
	// State register
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			st_r <= '0;
			st_r.ctrl <= CTRL_INIT;
			st_r.pull_dn <= ~{CTRL_INIT.b_pu, CTRL_INIT.a_pu};
			st_r.valid <= VALID_RST;
			st_r.coil_per <= COILDEB_RST;
			st_r.fade_len <= FADE_RST;
			st_r.map <= {NPAR{MAP_NONE}};
			st_r.prof <= PROF_A;
			st_r.gain <= GAIN_RST;
			st_r.wait_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end
	// Outputs straight from state flops
	assign AVS_READDATA = st_r.rdata;
	assign AVS_WAITREQUEST = st_r.wait_r;
	assign PULL_UP_EN = {st_r.ctrl.b_pu, st_r.ctrl.a_pu};
	assign PULL_DOWN_EN = st_r.pull_dn;
	assign PROFILE = st_r.prof;
	assign FADE_OUT = st_r.fade;
	assign INDICATOR_REQ = st_r.ind_req;
	assign INDICATOR_ID = st_r.ind_id;
	assign VOL_GAIN = st_r.gain;
	assign PARAM_VAL = st_r.par;
	// Checks
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);
	sequence s_bus_ask;
		req && AVS_WAITREQUEST;
	endsequence
	sequence s_bus_ans;
		!AVS_WAITREQUEST;
	endsequence
	sequence s_coil_in;
		coil_enter;
	endsequence
	sequence s_in_d;
		PROFILE == PROF_D && st_r.in_coil;
	endsequence
	AST_RESET_A: assert property ($rose(RST_N) |-> PROFILE == PROF_A)
		else $error("profile not A after reset");
	AST_PRESS_NEXT: assert property (a_take && up_tgt != PROFILE |=> PROFILE == $past(up_tgt))
		else $error("press did not load next valid profile");
	AST_WRAP_A: assert property (a_take && (vmask >> (3'(PROFILE) + 3'h1)) == 4'h0 |=> PROFILE == PROF_A)
		else $error("no wrap to profile A");
	AST_COIL_ENTER: assert property (s_coil_in |=> s_in_d)
		else $error("coil closure did not enter D");
	AST_COIL_HOLD: assert property (st_r.in_coil && b_closed |=> s_in_d ##1 s_in_d)
		else $error("left D while closed");
	AST_COIL_BACK: assert property (coil_leave |=> PROFILE == $past(st_r.saved) && !st_r.in_coil)
		else $error("coil exit did not restore profile");
	AST_FADE_ON: assert property ($changed(PROFILE) |-> FADE_OUT)
		else $error("profile change without fade");
	AST_IND_ID: assert property (INDICATOR_REQ |-> INDICATOR_ID == PROFILE && $changed(PROFILE))
		else $error("indicator not tied to destination");
	AST_FADE_LOCK: assert property (busy && !$changed(PROFILE) |=> $stable(PROFILE))
		else $error("profile changed during fade");
	AST_VOL_ONE: assert property (!(st_r.ctrl.vol_ana && st_r.ctrl.vol_dig))
		else $error("both volume sources enabled");
	AST_BUS_ANS: assert property (s_bus_ask |=> s_bus_ans ##1 AVS_WAITREQUEST) // Bus answer timing
		else $error("bus answer not one cycle");
	AST_GAIN_UP: assert property (st_r.ctrl.vol_dig && !st_r.ctrl.rocker_ms && rel[SW_UP] && VOL_GAIN != GAIN_MAX
		|=> VOL_GAIN == $past(VOL_GAIN) + 6'h01)
		else $error("up release did not raise gain");
endmodule // umsel_top
`default_nettype wire

// *** testbench/umsel_far.sv ***
// Far-side model: select switches, reed switch, volume rocker and pots.
// Assumes the bench sets closures and pot positions right after MCLK edges.
`timescale 1ns/10ps
`default_nettype none
module umsel_far import umsel_pkg::*; (
	input wire logic clk,
	input wire logic [3:0] closed,
	input wire logic [1:0] pull_up,
	input wire logic vol_pu,
	input wire logic [39:0] pos,
	output logic [3:0] pin,
	output umsel_smp_t smp
);
	logic [3:0] last = 4'h0; // Settled contact state
	logic [3:0] bmask = 4'h0; // Contacts still chattering
	logic [1:0] bcnt = 2'h0; // Chatter cycles left
	logic tgl = 1'b0; // Chatter phase
	logic [2:0] ch = 3'h0; // Next channel to convert
	logic [3:0] eff; // Contact state at the pin
	initial smp = '0;
	// Contacts chatter for three cycles after every change
	always @(posedge clk) begin
		tgl <= ~tgl;
		if (closed != last) begin
			bmask <= closed ^ last;
			last <= closed;
			bcnt <= 2'h3;
		end else if (bcnt != 2'h0) begin
			bcnt <= bcnt - 2'h1;
		end
	end
	assign eff = last ^ ((bcnt != 2'h0) ? (bmask & {4{tgl}}) : 4'h0);
	// Closed contact pulls the pin against the enabled pull
	assign pin = eff ^ {{2{vol_pu}}, pull_up};
	// Round-robin conversion of four trimmers and the volume pot
	always @(posedge clk) begin
		if (!smp.vld) begin
			smp.vld <= 1'b1;
			smp.ch <= ch;
			smp.pos <= pos[ch*8 +: 8];
			ch <= (ch == CH_VOL) ? 3'h0 : ch + 3'h1;
		end else begin
			smp.vld <= 1'b0;
		end
	end
endmodule // umsel_far
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking bench for the profile select and volume block.
// Assumes the far-side model; switch filter shortened to 4 cycles.
`timescale 1ns/10ps
`default_nettype none
module testbench import umsel_pkg::*; ;
	localparam int DEB = 4; // Shortened switch filter
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] adr = 6'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'hF;
	logic [31:0] rdata;
	logic waitreq;
	logic [3:0] pin;
	logic [1:0] pu_en;
	logic [1:0] pd_en;
	umsel_smp_t smp;
	logic [1:0] prof;
	logic [1:0] ind_id;
	logic fade;
	logic ireq;
	logic [5:0] gain;
	logic [NPAR*4-1:0] param;
	logic [3:0] closed = 4'h0; // Contacts held by the user
	logic [39:0] pot = 40'h0; // Pot positions
	logic fade_q = 1'b0;
	int fades = 0; // Fade starts seen
	int inds = 0; // Indicator pulses seen
	int err_count = 0;
	int cmp_count = 0;
	logic [31:0] rd; // Last read data
	logic [5:0] ofs [4] = '{OFS_CTRL, OFS_VALID, OFS_COILDEB, OFS_FADE};
	logic [31:0] rv [4] = '{{19'h0, CTRL_RST}, {28'h0, VALID_RST}, {16'h0, COILDEB_RST}, {16'h0, FADE_RST}};

	umsel_top #(.SW_DEB(DEB)) dut_u (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(adr), .AVS_READ(read),
		.AVS_WRITE(write), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(waitreq), .PROFILE_SELECT_IN_A(pin[0]), .PROFILE_SELECT_IN_B(pin[1]),
		.VOLUME_UP_PIN(pin[2]), .VOLUME_DOWN_PIN(pin[3]), .PULL_UP_EN(pu_en), .PULL_DOWN_EN(pd_en),
		.TRIM_SAMPLE(smp), .PROFILE(prof), .FADE_OUT(fade), .INDICATOR_REQ(ireq), .INDICATOR_ID(ind_id),
		.VOL_GAIN(gain), .PARAM_VAL(param));
	umsel_far far_u (.clk(mclk), .closed(closed), .pull_up(pu_en), .vol_pu(1'b0), .pos(pot), .pin(pin),
		.smp(smp));

	// Clock at 20 MHz
	initial begin
		forever #25 mclk = ~mclk;
	end
	// Count fade starts and indicator pulses
	always @(posedge mclk) begin
		fade_q <= fade;
		if (fade && !fade_q) fades++;
		if (ireq) inds++;
	end

	// Verdict and end of run
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// One comparison
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// One Avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		adr <= a;
		wdat <= d;
		be <= 4'hF;
		read <= ~wr;
		write <= wr;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (!waitreq) break;
		end
		if (n == 20) begin
			chk("waitrequest", 32'h0, 32'h1);
			test_done();
		end
		rd = rdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask
	// Press and release one switch; nothing may act while it is held
	task automatic hit(input int i);
		logic [7:0] was;
		was = {prof, gain};
		closed[i] <= 1'b1;
		cyc(16);
		chk("held switch", {24'h0, was}, {24'h0, prof, gain});
		closed[i] <= 1'b0;
		cyc(24);
	endtask
	// Press that must land in profile p
	task automatic step(input int i, input logic [1:0] p);
		int f;
		f = fades;
		hit(i);
		chk("profile", {30'h0, p}, {30'h0, prof});
		chk("indicator id", {30'h0, p}, {30'h0, ind_id});
		chk("fade count", f + 1, fades);
		chk("indicator count", fades, inds);
	endtask

	initial begin
		cyc(3);
		rst_n <= 1'b1;
		chk("start profile", 32'h0, {30'h0, prof});
		chk("gain", {26'h0, GAIN_RST}, {26'h0, gain});
		chk("pulls", 32'h3, {28'h0, pu_en, pd_en});
		for (int k = 0; k < 4; k++) begin
			bus(1'b0, ofs[k], 32'h0);
			chk("register reset", rv[k], rd);
		end
		bus(1'b1, 6'h18, 32'hFFFF);
		bus(1'b0, 6'h18, 32'h0);
		chk("unmapped", 32'h0, rd);
		$display("test reset done");
		bus(1'b1, OFS_FADE, 32'h2);
		bus(1'b1, OFS_COILDEB, 32'h14);
		bus(1'b1, OFS_VALID, 32'hF);
		for (int k = 1; k < 5; k++) begin
			step(SW_A, k[1:0]);
		end
		bus(1'b1, OFS_VALID, 32'h5);
		step(SW_A, 2'h2);
		step(SW_A, 2'h0);
		bus(1'b1, OFS_VALID, 32'h1);
		hit(SW_A);
		chk("single profile", 32'h0, {30'h0, prof});
		$display("test momentary done");
		bus(1'b1, OFS_VALID, 32'hF);
		bus(1'b1, OFS_CTRL, 32'h410);
		step(SW_A, 2'h1);
		closed[SW_B] <= 1'b1;
		cyc(24);
		chk("coil entry", {30'h0, PROF_D}, {30'h0, prof});
		chk("coil indicator", {30'h0, PROF_D}, {30'h0, ind_id});
		hit(SW_A);
		chk("press in coil", {30'h0, PROF_D}, {30'h0, prof});
		closed[SW_B] <= 1'b0;
		cyc(12);
		closed[SW_B] <= 1'b1;
		cyc(24);
		chk("short open", {30'h0, PROF_D}, {30'h0, prof});
		closed[SW_B] <= 1'b0;
		cyc(48);
		chk("coil exit", {30'h0, PROF_B}, {30'h0, prof});
		step(SW_A, 2'h2);
		step(SW_A, 2'h0);
		bus(1'b1, OFS_CTRL, 32'h430);
		closed[SW_B] <= 1'b1;
		cyc(24);
		chk("disabled input", {30'h0, PROF_A}, {30'h0, prof});
		closed[SW_B] <= 1'b0;
		cyc(24);
		$display("test coil done");
		bus(1'b1, OFS_CTRL, 32'h440);
		hit(SW_UP);
		chk("gain up", 32'h21, {26'h0, gain});
		hit(SW_DN);
		hit(SW_DN);
		chk("gain down", 32'h1F, {26'h0, gain});
		bus(1'b1, OFS_CTRL, 32'h4C0);
		bus(1'b0, OFS_CTRL, 32'h0);
		chk("one volume source", 32'h440, rd);
		bus(1'b1, OFS_CTRL, 32'h540);
		step(SW_UP, 2'h1);
		step(SW_DN, 2'h0);
		step(SW_DN, 2'h3);
		chk("rocker gain", 32'h1F, {26'h0, gain});
		$display("test digital volume done");
		pot[39:32] <= 8'hFC;
		bus(1'b1, OFS_CTRL, 32'h480);
		cyc(20);
		chk("linear taper", 32'h3F, {26'h0, gain});
		bus(1'b1, OFS_CTRL, 32'h680);
		cyc(20);
		chk("log taper", 32'h3E, {26'h0, gain});
		bus(1'b1, OFS_CTRL, 32'hC00);
		bus(1'b1, OFS_TRIMMAP, 32'h23);
		bus(1'b1, OFS_TRIMMAP, 32'h31);
		pot[15:8] <= 8'hA5;
		cyc(20);
		chk("param 3", 32'hA, {28'h0, param[15:12]});
		chk("param 17", 32'hA, {28'h0, param[71:68]});
		chk("param 4", 32'h0, {28'h0, param[19:16]});
		pot[15:8] <= 8'h30;
		cyc(20);
		chk("param 3 moved", 32'h3, {28'h0, param[15:12]});
		$display("test analog done");
		begin
			int f0;
			int i0;
			f0 = fades;
			i0 = inds;
			bus(1'b1, OFS_CTRL, 32'h1);
			closed[SW_A] <= 1'b1;
			cyc(16);
			chk("static closed", {30'h0, PROF_B}, {30'h0, prof});
			closed[SW_A] <= 1'b0;
			cyc(16);
			chk("static open", {30'h0, PROF_A}, {30'h0, prof});
			chk("static fades", f0 + 3, fades);
			chk("indicator off", i0, inds);
			$display("test static done");
		end
		bus(1'b1, OFS_CTRL, 32'h40C);
		cyc(4);
		chk("pull select", 32'hC, {28'h0, pu_en, pd_en});
		$display("test pulls done");
		test_done();
	end
endmodule // testbench
`default_nettype wire
